/* input_loopback_self_test.sv */
// Purpose: Input loopback self-test with change detection and capture strobe
// Assumes: Debounce clock arrives as a plain input sampled on sys_clk
// Notes: Capture FIFO sits outside; captureWrite is a one-cycle write strobe
`timescale 1ns/1ns
module input_loopback_self_test (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [31:0] extInputs,
	input wire logic debounceClk,
	input wire logic testModeWrite,
	input wire logic testModeValue,
	input wire logic hostWrite,
	input wire logic [1:0] hostByte,
	input wire logic [7:0] hostWrData,
	input wire logic [1:0] changeMode,
	input wire logic [31:0] riseEnable,
	input wire logic [31:0] fallEnable,
	input wire logic failOn,
	input wire logic failOff,
	output logic [31:0] hostRdData,
	output logic testMode,
	output logic captureWrite,
	output logic [31:0] captureData,
	output logic [31:0] prevState,
	output logic failureIndicator
);
	chan_path_if cp ();

	loopback_pkg::chan_t extSync1Q, extSync2Q, extSync3Q, extLevelQ, extLevelD;
	logic [loopback_pkg::SYNC_DEPTH-1:0] dbSyncQ;
	logic dbLevelQ, dbLevelD, dbTick;
	logic testModeQ, testModeD, failQ, failD;
	loopback_pkg::detect_state_e stateQ, stateD;
	loopback_pkg::chan_t prevQ, prevD, capQ, capD, rdQ;
	logic flagged;

	// Level taken only when two late stages agree, filtering a metastable first stage
	always_comb begin
		for (int i = 0; i < loopback_pkg::NUM_CH; i++) begin
			extLevelD[i] = (extSync2Q[i] == extSync3Q[i]) ? extSync3Q[i] : extLevelQ[i];
		end
		dbLevelD = (dbSyncQ[1] == dbSyncQ[2]) ? dbSyncQ[2] : dbLevelQ;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			extSync1Q <= loopback_pkg::CH_RESET;
			extSync2Q <= loopback_pkg::CH_RESET;
			extSync3Q <= loopback_pkg::CH_RESET;
			extLevelQ <= loopback_pkg::CH_RESET;
			// Reset high: a debounce level already high at release gives no false tick
			dbSyncQ <= '1;
			dbLevelQ <= 1'h1;
		end else begin
			extSync1Q <= extInputs;
			extSync2Q <= extSync1Q;
			extSync3Q <= extSync2Q;
			extLevelQ <= extLevelD;
			dbSyncQ <= {dbSyncQ[1:0], debounceClk};
			dbLevelQ <= dbLevelD;
		end
	end

	assign dbTick = dbLevelD && !dbLevelQ;

	// Control bits: set wins over clear on the indicator
	always_comb begin
		testModeD = testModeWrite ? testModeValue : testModeQ;
		failD = failQ;
		if (failOff) begin
			failD = 1'h0;
		end
		if (failOn) begin
			failD = 1'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			testModeQ <= loopback_pkg::TEST_RESET;
			failQ <= loopback_pkg::FAIL_RESET;
		end else begin
			testModeQ <= testModeD;
			failQ <= failD;
		end
	end

	assign cp.extData = extLevelQ;
	assign cp.testEn = testModeQ;
	assign cp.wrEn = hostWrite;
	assign cp.wrByte = hostByte;
	assign cp.wrData = hostWrData;

	input_select u_select (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.cp(cp.sel)
	);

	// Same detector whatever the source, so test patterns exercise it fully
	always_comb begin
		flagged = (changeMode != loopback_pkg::CD_MODE_NONE) &&
			|((cp.chanData & ~prevQ & riseEnable) | (~cp.chanData & prevQ & fallEnable));
		stateD = stateQ;
		prevD = prevQ;
		capD = capQ;
		case (stateQ)
			loopback_pkg::CD_IDLE: begin
				if (dbTick && flagged) begin
					capD = cp.chanData;
					stateD = loopback_pkg::CD_WRITE;
				end else if (dbTick) begin
					prevD = cp.chanData;
				end
			end
			loopback_pkg::CD_WRITE: begin
				prevD = capQ;
				stateD = loopback_pkg::CD_IDLE;
			end
			default: begin
				stateD = loopback_pkg::CD_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			stateQ <= loopback_pkg::CD_IDLE;
			prevQ <= loopback_pkg::CH_RESET;
			capQ <= loopback_pkg::CH_RESET;
			rdQ <= loopback_pkg::CH_RESET;
		end else begin
			stateQ <= stateD;
			prevQ <= prevD;
			capQ <= capD;
			rdQ <= cp.chanData;
		end
	end

	assign captureWrite = (stateQ == loopback_pkg::CD_WRITE);
	assign captureData = capQ;
	assign prevState = prevQ;
	assign hostRdData = rdQ;
	assign testMode = testModeQ;
	assign failureIndicator = failQ;

	a_test_reset_clear: assert property (@(posedge sys_clk)
		sys_rst |=> !testModeQ)
		else $error("Test mode survives reset");
	a_fail_reset_on: assert property (@(posedge sys_clk)
		sys_rst |=> failureIndicator)
		else $error("Fail indicator dark after reset");
	a_fail_holds_on: assert property (@(posedge sys_clk) disable iff (sys_rst)
		failureIndicator && !failOff |=> failureIndicator)
		else $error("Fail indicator cleared by itself");
	a_flagged_capture: assert property (@(posedge sys_clk) disable iff (sys_rst)
		stateQ == loopback_pkg::CD_IDLE && dbTick && flagged
		|=> captureWrite && captureData == $past(cp.chanData))
		else $error("Flagged change not captured");
	a_store_after_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
		captureWrite |=> !captureWrite && prevState == $past(captureData))
		else $error("Previous state not stored after write");
	a_unflagged_store: assert property (@(posedge sys_clk) disable iff (sys_rst)
		stateQ == loopback_pkg::CD_IDLE && dbTick && !flagged
		|=> prevState == $past(cp.chanData) && !captureWrite)
		else $error("Unflagged sample not stored");
	a_no_tick_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
		stateQ == loopback_pkg::CD_IDLE && !dbTick |=> $stable(prevState))
		else $error("Previous state moved without debounce edge");
	a_mode_none_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst)
		stateQ == loopback_pkg::CD_IDLE && changeMode == loopback_pkg::CD_MODE_NONE
		|=> !captureWrite)
		else $error("Capture in no-interrupt mode");
	a_readback_test: assert property (@(posedge sys_clk) disable iff (sys_rst)
		testModeQ |=> hostRdData == $past(cp.testData))
		else $error("Readback shows external data in test");

	// Checks on external masking and readback, input level, mode bit, fail indicator and reset outputs
	a_ext_masked: assert property (@(posedge sys_clk) disable iff (sys_rst)
		testModeQ && !hostWrite ##1 testModeQ |=> $stable(hostRdData))
		else $error("External change reached readback in test");
	a_ext_readback: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!testModeQ |=> hostRdData == $past(extLevelQ))
		else $error("Readback shows test data outside test");
	a_ext_level: assert property (@(posedge sys_clk) disable iff (sys_rst)
		extSync2Q == extSync3Q |=> extLevelQ == $past(extSync3Q))
		else $error("Agreed input level not taken");
	a_mode_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
		testModeWrite |=> testMode == $past(testModeValue))
		else $error("Test mode bit not loaded");
	a_mode_holds: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!testModeWrite |=> $stable(testMode))
		else $error("Test mode bit moved without a write");
	a_fail_off_clears: assert property (@(posedge sys_clk) disable iff (sys_rst)
		failOff && !failOn |=> !failureIndicator)
		else $error("Fail indicator not extinguished");
	a_fail_on_wins: assert property (@(posedge sys_clk) disable iff (sys_rst)
		failOn |=> failureIndicator)
		else $error("Fail indicator not lit");
	a_reset_outputs: assert property (@(posedge sys_clk)
		sys_rst |=> !captureWrite && prevState == loopback_pkg::CH_RESET
		&& hostRdData == loopback_pkg::CH_RESET && captureData == loopback_pkg::CH_RESET)
		else $error("Outputs not cleared by reset");
	// Captured word may only move together with its strobe
	a_capture_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!captureWrite |-> $stable(captureData))
		else $error("Capture data moved without strobe");
	a_no_tick_capture: assert property (@(posedge sys_clk) disable iff (sys_rst)
		stateQ == loopback_pkg::CD_IDLE && !dbTick |=> !captureWrite)
		else $error("Capture without debounce edge");
	a_test_reach_detect: assert property (@(posedge sys_clk) disable iff (sys_rst)
		stateQ == loopback_pkg::CD_IDLE && dbTick && testModeQ
		|=> (captureWrite ? captureData : prevState) == $past(cp.testData))
		else $error("Test data missed the detector");

	c_test_capture: cover property (@(posedge sys_clk) disable iff (sys_rst)
		testModeQ && captureWrite);
	c_ext_capture: cover property (@(posedge sys_clk) disable iff (sys_rst)
		!testModeQ && captureWrite);
	c_fail_cleared: cover property (@(posedge sys_clk) disable iff (sys_rst)
		failureIndicator ##1 !failureIndicator);
	c_unflagged_store: cover property (@(posedge sys_clk) disable iff (sys_rst)
		stateQ == loopback_pkg::CD_IDLE && dbTick && !flagged);
	c_test_write: cover property (@(posedge sys_clk) disable iff (sys_rst)
		testModeQ && hostWrite);
endmodule // input_loopback_self_test

/* loopback_pkg.sv */
// Purpose: Shared constants and types for the input loopback self-test block
// Assumes: Single clock domain on sys_clk, synchronous active-high reset
// Notes: Channel 31 sits in the top bit of the 32-bit channel word
//
// Functional notes
// - In test mode, host writes at input data addresses go into test registers.
// - Enabled test registers replace external inputs; host reads return the test values.
// - One test-mode bit enables all test registers together, never per byte.
// - Byte 0 holds channels 31..24, byte 3 holds channels 7..0.
// - Test data feeds change detection and capture exactly like external data.
// - Change detection samples channel data on each rising debounce clock edge.
// - While test overrides inputs, external transitions are not captured.
// - An input level counts only when present at a rising bus clock edge.
// - Failure indicator lights at power-up and reset, stays until software clears it.
// - Unflagged debounce stores all channels as previous; flagged stores after FIFO write.
package loopback_pkg;
	localparam int NUM_CH = 32;
	localparam int BYTE_W = 8;
	localparam int NUM_BYTES = 4;
	localparam int SYNC_DEPTH = 3;
	localparam logic FAIL_RESET = 1'h1;
	localparam logic TEST_RESET = 1'h0;
	localparam logic [1:0] CD_MODE_NONE = 2'h0;
	localparam logic [NUM_CH-1:0] CH_RESET = 32'h0000_0000;

	typedef enum logic {
		CD_IDLE = 1'h0,
		CD_WRITE = 1'h1
	} detect_state_e;

	typedef logic [NUM_CH-1:0] chan_t;
	typedef logic [BYTE_W-1:0] byte_t;
	typedef logic [1:0] byte_sel_t;
endpackage

/* chan_path_if.sv */
// Purpose: Channel path between the top and the input selector
// Assumes: All signals on sys_clk
// Notes: None
`timescale 1ns/1ns
interface chan_path_if;
	loopback_pkg::chan_t extData;
	loopback_pkg::chan_t chanData;
	loopback_pkg::chan_t testData;
	logic testEn;
	logic wrEn;
	loopback_pkg::byte_sel_t wrByte;
	loopback_pkg::byte_t wrData;

	modport sel (
		input extData,
		input testEn,
		input wrEn,
		input wrByte,
		input wrData,
		output chanData,
		output testData
	);
	modport top (
		output extData,
		output testEn,
		output wrEn,
		output wrByte,
		output wrData,
		input chanData,
		input testData
	);
endinterface

/* input_select.sv */
// Purpose: Test output registers and the external/test channel selector
// Assumes: extData already synchronised to sys_clk
// Notes: Selector is combinational so test data reaches detection at once
`timescale 1ns/1ns
module input_select (
	input wire logic sys_clk,
	input wire logic sys_rst,
	chan_path_if.sel cp
);
	loopback_pkg::chan_t testQ;
	loopback_pkg::chan_t testD;

	// Writes outside test mode are dropped; registers keep their last test pattern
	generate
		for (genvar b = 0; b < loopback_pkg::NUM_BYTES; b++) begin : g_byte
			localparam int HI = loopback_pkg::NUM_CH - 1 - b * loopback_pkg::BYTE_W;
			always_comb begin
				testD[HI -: loopback_pkg::BYTE_W] = testQ[HI -: loopback_pkg::BYTE_W];
				if (cp.wrEn && cp.testEn && cp.wrByte == loopback_pkg::byte_sel_t'(b)) begin
					testD[HI -: loopback_pkg::BYTE_W] = cp.wrData;
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			testQ <= loopback_pkg::CH_RESET;
		end else begin
			testQ <= testD;
		end
	end

	// One select for all bytes, no per-byte enable
	assign cp.chanData = cp.testEn ? testQ : cp.extData;
	assign cp.testData = testQ;

	a_test_byte0_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
		cp.wrEn && cp.testEn && cp.wrByte == 2'h0 |=> testQ[31:24] == $past(cp.wrData))
		else $error("Test byte 0 write lost");
	a_test_substitute: assert property (@(posedge sys_clk) disable iff (sys_rst)
		cp.testEn && !cp.wrEn ##1 cp.testEn |-> $stable(cp.chanData))
		else $error("Test data not substituted");
	a_ext_passthrough: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!cp.testEn |-> cp.chanData == cp.extData)
		else $error("External data not passed");
	a_write_ignored: assert property (@(posedge sys_clk) disable iff (sys_rst)
		cp.wrEn && !cp.testEn |=> $stable(testQ))
		else $error("Write stored outside test mode");
endmodule // input_select

/* debounce_source.sv */
// Purpose: Far-side source of the debounce clock for the loopback block
// Assumes: Stepped off sys_clk by the bench
// Notes: Level stands still between ticks; each tick is a low phase then a rise
`timescale 1ns/1ns
module debounce_source (
	input wire logic sys_clk,
	output logic debounceClk
);
	initial debounceClk = 1'h0;
	// Six cycles low so the 3-stage synchroniser surely sees a fresh rise
	task automatic tick();
		#10 debounceClk = 1'h0;
		repeat (6) @(posedge sys_clk);
		#10 debounceClk = 1'h1;
	endtask
endmodule // debounce_source

/* tb_top.sv */
// Purpose: Self-checking bench for the input loopback self-test block
// Assumes: Capture FIFO is empty at start, so every strobe is test data
// Notes: Inputs change 10 ns after each rising edge
`timescale 1ns/1ns
module tb_top;
	logic sys_clk, sys_rst, debounceClk, testModeWrite, testModeValue, hostWrite, failOn, failOff;
	logic testMode, captureWrite, failureIndicator, seen;
	logic [1:0] hostByte, changeMode;
	logic [7:0] hostWrData;
	logic [31:0] extInputs, riseEnable, fallEnable, hostRdData, captureData, prevState;
	int fail_count = 0;
	int checked = 0;
	debounce_source u_src (.sys_clk(sys_clk), .debounceClk(debounceClk));
	input_loopback_self_test u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.extInputs(extInputs), .debounceClk(debounceClk), .testModeWrite(testModeWrite),
		.testModeValue(testModeValue), .hostWrite(hostWrite), .hostByte(hostByte),
		.hostWrData(hostWrData), .changeMode(changeMode), .riseEnable(riseEnable),
		.fallEnable(fallEnable), .failOn(failOn), .failOff(failOff), .hostRdData(hostRdData),
		.testMode(testMode), .captureWrite(captureWrite), .captureData(captureData),
		.prevState(prevState), .failureIndicator(failureIndicator));
	initial begin
		sys_clk = 1'h0;
		forever #50 sys_clk = ~sys_clk;
	end
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#10;
	endtask
	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic conclude();
		$display("Checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic setMode(input logic v);
		testModeWrite = 1'h1;
		testModeValue = v;
		step(1);
		testModeWrite = 1'h0;
		step(1);
	endtask
	// Bounded watch for the one-cycle capture strobe
	task automatic waitCap(output logic hit);
		hit = 1'h0;
		for (int i = 0; i < 20 && !hit; i++) begin
			step(1);
			hit = (captureWrite === 1'h1);
		end
	endtask
	task automatic t_reset();
		check("testMode", {31'h0, testMode}, 32'h0);
		check("failLit", {31'h0, failureIndicator}, 32'h1);
		check("prevState", prevState, 32'h0);
		failOff = 1'h1;
		step(1);
		failOff = 1'h0;
		step(1);
		check("failOff", {31'h0, failureIndicator}, 32'h0);
		failOn = 1'h1;
		failOff = 1'h1;
		step(1);
		failOn = 1'h0;
		failOff = 1'h0;
		step(1);
		check("failOn", {31'h0, failureIndicator}, 32'h1);
		$display("reset test done");
	endtask
	task automatic t_refuse();
		extInputs = 32'h1234_5678;
		hostWrite = 1'h1;
		hostWrData = 8'ha5;
		step(1);
		hostWrite = 1'h0;
		step(8);
		check("extRead", hostRdData, 32'h1234_5678);
		setMode(1'h1);
		step(2);
		check("refused", hostRdData, 32'h0);
		$display("refuse test done");
	endtask
	task automatic t_loop();
		hostWrite = 1'h1;
		for (int b = 0; b < 4; b++) begin
			hostByte = b[1:0];
			hostWrData = 8'ha5 + 8'h11 * b[7:0];
			step(1);
		end
		hostWrite = 1'h0;
		step(3);
		check("loopRead", hostRdData, 32'ha5b6_c7d8);
		extInputs = 32'hedcb_a987;
		step(8);
		check("extMasked", hostRdData, 32'ha5b6_c7d8);
		$display("loopback test done");
	endtask
	task automatic t_detect();
		u_src.tick();
		waitCap(seen);
		check("quietMode", {31'h0, seen}, 32'h0);
		check("prevPlain", prevState, 32'ha5b6_c7d8);
		changeMode = 2'h1;
		hostWrite = 1'h1;
		hostByte = 2'h3;
		hostWrData = 8'hff;
		step(1);
		hostWrite = 1'h0;
		u_src.tick();
		waitCap(seen);
		check("captureSeen", {31'h0, seen}, 32'h1);
		if (seen !== 1'h1) begin
			conclude();
		end
		check("capture", captureData, 32'ha5b6_c7ff);
		step(1);
		check("prevFlag", prevState, 32'ha5b6_c7ff);
		riseEnable = 32'h0;
		fallEnable = 32'h0000_000f;
		hostWrite = 1'h1;
		hostWrData = 8'hf0;
		step(1);
		hostWrite = 1'h0;
		u_src.tick();
		waitCap(seen);
		check("fallSeen", {31'h0, seen}, 32'h1);
		if (seen !== 1'h1) begin
			conclude();
		end
		check("fallCapture", captureData, 32'ha5b6_c7f0);
		hostWrite = 1'h1;
		hostWrData = 8'h0f;
		step(1);
		hostWrite = 1'h0;
		u_src.tick();
		waitCap(seen);
		check("riseMasked", {31'h0, seen}, 32'h0);
		check("prevMasked", prevState, 32'ha5b6_c70f);
		$display("detect test done");
	endtask
	task automatic t_exit();
		setMode(1'h0);
		step(8);
		check("backToExt", hostRdData, 32'hedcb_a987);
		setMode(1'h1);
		sys_rst = 1'h1;
		step(3);
		sys_rst = 1'h0;
		step(1);
		check("rstMode", {31'h0, testMode}, 32'h0);
		check("rstFail", {31'h0, failureIndicator}, 32'h1);
		$display("exit test done");
	endtask
	// Watchdog: a hang counts as a mismatch
	initial begin
		#3000000;
		fail_count++;
		conclude();
	end
	initial begin
		{sys_rst, testModeWrite, testModeValue, hostWrite, failOn, failOff} = 6'h20;
		{hostByte, changeMode, hostWrData} = 12'h0;
		extInputs = 32'h0;
		riseEnable = 32'hffff_ffff;
		fallEnable = 32'h0;
		step(20);
		sys_rst = 1'h0;
		step(1);
		t_reset();
		t_refuse();
		t_loop();
		t_detect();
		t_exit();
		conclude();
	end
endmodule // tb_top
